//--- verilog/aio_pkg_tick.sv
// Purpose: Shared constants for the analog I/O scan sequencer, and a small tick counter
// Assumes: Single 10 MHz clock sys_clk, asynchronous active-low reset rst_b
// Notes: Times are held in ns; cycle counts are derived from the clock period
package aio_pkg;
  // ==========================================================================
  // Channel counts
  localparam int NUM_AI = 4;
  localparam int NUM_AO = 4;
  localparam int OUT_SLOTS = 4;
  localparam int CH_W = 2;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  // ==========================================================================
  // Timing
  localparam int CLK_NS = 100;
  localparam int T_CONV_NS = 500000;
  localparam int CONV_CYC = (T_CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_UNIT_NS = 500000;
  localparam int UNIT_CYC = T_UNIT_NS / CLK_NS;
  localparam int CNT_W = 16;
  // ==========================================================================
  // Interrupt modes and parameter field widths
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_CYCLIC = 2'h1;
  localparam logic [1:0] MODE_CEND = 2'h2;
  localparam int TIME_W = 5;
  localparam logic [ADDR_W-1:0] BASE_ADDR_DEF = 16'h0100;
  localparam logic [ADDR_W-1:0] WORD_BYTES = 16'h0002;
  // ==========================================================================
  // Reset values of adopted parameters
  localparam logic [NUM_AI-1:0] AI_EN_RST = 4'hF;
  localparam logic [NUM_AO-1:0] AO_EN_RST = 4'hF;
  localparam logic [NUM_AI-1:0] DIAG_RST = 4'h0;
  localparam logic [TIME_W-1:0] TIME_RST = 5'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
endpackage

// Divider enabled by run: pulses tick on the last cycle of each N-cycle period, held at zero while run is low
module aio_tick #(
  parameter int N = aio_pkg::CONV_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Control
  input wire logic run,
  output logic tick
);
  logic [aio_pkg::CNT_W-1:0] cnt;
  logic [aio_pkg::CNT_W-1:0] next_cnt;

  always_comb
  begin
    tick = run && (cnt == aio_pkg::CNT_W'(N - 1));
    if (!run || tick)
    begin
      next_cnt = '0;
    end
    else
    begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= '0;
    end
    else
    begin
      cnt <= next_cnt;
    end
  end
endmodule

//--- verilog/aio_scan_seq.sv
// Purpose: Analog input/output scan sequencer with staged parameter adoption
// Assumes: Host logic on sys_clk; converter data arrives from pins and is synchronised
// Notes: Each channel is one 16-bit word; reads give inputs, writes set outputs
module aio_scan_seq #(
  parameter logic [aio_pkg::ADDR_W-1:0] BASE_ADDR = aio_pkg::BASE_ADDR_DEF,
  parameter int CONV_CYCLES = aio_pkg::CONV_CYC,
  parameter int UNIT_CYCLES = aio_pkg::UNIT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Host operating mode
  input wire logic cpu_run,
  // Parameter block (complete) and running dynamic update
  input wire logic prm_load,
  input wire logic dyn_load,
  input wire logic [aio_pkg::NUM_AI-1:0] prm_diag_en,
  input wire logic [aio_pkg::NUM_AI-1:0] prm_ai_en,
  input wire logic [aio_pkg::NUM_AO-1:0] prm_ao_en,
  input wire logic [1:0] prm_irq_mode,
  input wire logic [aio_pkg::TIME_W-1:0] prm_irq_time,
  // Host channel access
  input wire logic host_sel,
  input wire logic host_we,
  input wire logic [aio_pkg::ADDR_W-1:0] host_addr,
  input wire logic [aio_pkg::DATA_W-1:0] host_wdata,
  output logic [aio_pkg::DATA_W-1:0] host_rdata,
  output logic host_ack,
  output logic addr_err,
  // Converter side
  input wire logic [aio_pkg::DATA_W-1:0] adc_data,
  output logic adc_start,
  output logic [aio_pkg::CH_W-1:0] adc_ch,
  output logic dac_wr,
  output logic [aio_pkg::CH_W-1:0] dac_ch,
  output logic [aio_pkg::DATA_W-1:0] dac_data,
  // Status
  output logic [aio_pkg::NUM_AI-1:0] diag_en,
  output logic meas_busy,
  output logic hw_irq
);
  // ==========================================================================
  // Helpers
  // Lowest enabled channel at or above 'from'; found flag in the top bit
  function automatic logic [aio_pkg::CH_W:0] first_en(input logic [aio_pkg::NUM_AI-1:0] m,
                                                     input logic [aio_pkg::CH_W:0] from);
    logic [aio_pkg::CH_W:0] r;
    r = '0;
    for (int i = aio_pkg::NUM_AI - 1; i >= 0; i--)
    begin
      if (m[i] && (i >= int'(from)))
      begin
        r = {1'b1, aio_pkg::CH_W'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [aio_pkg::CH_W:0] word_of(input logic [aio_pkg::ADDR_W-1:0] a);
    logic [aio_pkg::ADDR_W-1:0] off;
    off = a - BASE_ADDR;
    return {(a >= BASE_ADDR) && (off < aio_pkg::WORD_BYTES * aio_pkg::ADDR_W'(aio_pkg::NUM_AI))
            && !a[0],
            off[aio_pkg::CH_W:1]};
  endfunction

  // ==========================================================================
  // Parameter staging
  logic run_q;
  logic run_rise;
  logic [aio_pkg::NUM_AI-1:0] pend_diag, next_pend_diag, next_diag_en;
  logic [aio_pkg::NUM_AI-1:0] pend_ai, next_pend_ai, act_ai, next_act_ai;
  logic [aio_pkg::NUM_AO-1:0] pend_ao, next_pend_ao, act_ao, next_act_ao;
  logic [1:0] pend_mode, next_pend_mode, act_mode, next_act_mode;
  logic [aio_pkg::TIME_W-1:0] pend_time, next_pend_time, act_time, next_act_time;
  logic dyn_pend, next_dyn_pend;
  logic cyc_edge;

  assign run_rise = cpu_run && !run_q;

  always_comb
  begin
    next_pend_diag = pend_diag;
    next_pend_ai = pend_ai;
    next_pend_ao = pend_ao;
    next_pend_mode = pend_mode;
    next_pend_time = pend_time;
    next_diag_en = diag_en;
    next_act_ai = act_ai;
    next_act_ao = act_ao;
    next_act_mode = act_mode;
    next_act_time = act_time;
    next_dyn_pend = dyn_pend;
    if (prm_load || dyn_load)
    begin
      if (prm_load)
      begin
        next_pend_diag = prm_diag_en;
      end
      next_pend_ai = prm_ai_en;
      next_pend_ao = prm_ao_en;
      next_pend_mode = prm_irq_mode;
      next_pend_time = prm_irq_time;
    end
    if (run_rise)
    begin
      // Whole staged set taken, static and dynamic alike
      next_diag_en = pend_diag;
      next_act_ai = pend_ai;
      next_act_ao = pend_ao;
      next_act_mode = pend_mode;
      next_act_time = pend_time;
      next_dyn_pend = 1'b0;
    end
    else if (dyn_pend && cyc_edge)
    begin
      // Dynamic fields only, and only at a measuring-cycle boundary
      next_act_ai = pend_ai;
      next_act_ao = pend_ao;
      next_act_mode = pend_mode;
      next_act_time = pend_time;
      next_dyn_pend = 1'b0;
    end
    // A write in the same cycle as a boundary adoption keeps its flag set; one at run_rise does not
    if (dyn_load && run_q)
    begin
      next_dyn_pend = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      run_q <= 1'b0;
      pend_diag <= aio_pkg::DIAG_RST;
      pend_ai <= aio_pkg::AI_EN_RST;
      pend_ao <= aio_pkg::AO_EN_RST;
      pend_mode <= aio_pkg::MODE_NONE;
      pend_time <= aio_pkg::TIME_RST;
      diag_en <= aio_pkg::DIAG_RST;
      act_ai <= aio_pkg::AI_EN_RST;
      act_ao <= aio_pkg::AO_EN_RST;
      act_mode <= aio_pkg::MODE_NONE;
      act_time <= aio_pkg::TIME_RST;
      dyn_pend <= 1'b0;
    end
    else
    begin
      run_q <= cpu_run;
      pend_diag <= next_pend_diag;
      pend_ai <= next_pend_ai;
      pend_ao <= next_pend_ao;
      pend_mode <= next_pend_mode;
      pend_time <= next_pend_time;
      diag_en <= next_diag_en;
      act_ai <= next_act_ai;
      act_ao <= next_act_ao;
      act_mode <= next_act_mode;
      act_time <= next_act_time;
      dyn_pend <= next_dyn_pend;
    end
  end

  // ==========================================================================
  // Timebases
  typedef enum logic [2:0] {
    AIO_M_IDLE = 3'b001,
    AIO_M_CONV = 3'b010,
    AIO_M_WAIT = 3'b100
  } aio_meas_t;
  aio_meas_t mstate, next_mstate;
  logic slot_tick, unit_tick, out_tick;
  logic [aio_pkg::TIME_W-1:0] per_cnt, next_per_cnt;
  logic per_hit;

  aio_tick #(.N(CONV_CYCLES)) u_slot (.sys_clk(sys_clk), .rst_b(rst_b),
    .run(mstate == AIO_M_CONV), .tick(slot_tick));
  aio_tick #(.N(UNIT_CYCLES)) u_unit (.sys_clk(sys_clk), .rst_b(rst_b),
    .run(run_q), .tick(unit_tick));
  aio_tick #(.N(CONV_CYCLES)) u_out (.sys_clk(sys_clk), .rst_b(rst_b),
    .run(run_q), .tick(out_tick));

  // Period of zero units behaves as one unit
  assign per_hit = unit_tick && (per_cnt + 1'b1 >= act_time);

  always_comb
  begin
    next_per_cnt = per_cnt;
    if (!run_q || per_hit)
    begin
      next_per_cnt = '0;
    end
    else if (unit_tick)
    begin
      next_per_cnt = per_cnt + 1'b1;
    end
  end

  // ==========================================================================
  // Measuring cycle
  logic [aio_pkg::DATA_W-1:0] adc_s1, adc_s2;
  logic [aio_pkg::DATA_W-1:0] ai_val [aio_pkg::NUM_AI];
  logic [aio_pkg::CH_W:0] nxt_first, nxt_after;
  logic next_adc_start, next_busy, next_irq, cyc_end;
  logic [aio_pkg::CH_W-1:0] next_adc_ch;
  logic cend_due, next_cend_due;

  assign nxt_first = first_en(act_ai, '0);
  assign nxt_after = first_en(act_ai, {1'b0, adc_ch} + 1'b1);
  assign cyc_end = (mstate == AIO_M_CONV) && slot_tick && !nxt_after[aio_pkg::CH_W];
  assign cyc_edge = (mstate != AIO_M_CONV);

  always_comb
  begin
    next_mstate = mstate;
    next_adc_ch = adc_ch;
    next_adc_start = 1'b0;
    next_cend_due = run_q && (cend_due || (per_hit && act_mode == aio_pkg::MODE_CEND));
    case (mstate)
      AIO_M_IDLE, AIO_M_WAIT:
      begin
        // Cycle-end mode waits for its cycle time; other modes run free
        if (run_q && nxt_first[aio_pkg::CH_W] && !dyn_pend &&
            (act_mode != aio_pkg::MODE_CEND || cend_due))
        begin
          next_mstate = AIO_M_CONV;
          next_adc_ch = nxt_first[aio_pkg::CH_W-1:0];
          next_adc_start = 1'b1;
          // A period tick in the start cycle is kept, so no cycle time is lost
          next_cend_due = per_hit && act_mode == aio_pkg::MODE_CEND;
        end
      end
      AIO_M_CONV:
      begin
        if (!run_q)
        begin
          next_mstate = AIO_M_IDLE;
        end
        else if (slot_tick && nxt_after[aio_pkg::CH_W])
        begin
          // Disabled channels take no time at all
          next_adc_ch = nxt_after[aio_pkg::CH_W-1:0];
          next_adc_start = 1'b1;
        end
        else if (cyc_end)
        begin
          next_mstate = AIO_M_WAIT;
        end
      end
      default:
      begin
        next_mstate = AIO_M_IDLE;
      end
    endcase
    next_busy = (next_mstate == AIO_M_CONV);
    next_irq = run_q && ((act_mode == aio_pkg::MODE_CYCLIC && per_hit) ||
                         (act_mode == aio_pkg::MODE_CEND && cyc_end));
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mstate <= AIO_M_IDLE;
      adc_ch <= '0;
      adc_start <= 1'b0;
      meas_busy <= 1'b0;
      hw_irq <= 1'b0;
      per_cnt <= '0;
      cend_due <= 1'b0;
      adc_s1 <= aio_pkg::DATA_RST;
      adc_s2 <= aio_pkg::DATA_RST;
    end
    else
    begin
      mstate <= next_mstate;
      adc_ch <= next_adc_ch;
      adc_start <= next_adc_start;
      meas_busy <= next_busy;
      hw_irq <= next_irq;
      per_cnt <= next_per_cnt;
      cend_due <= next_cend_due;
      adc_s1 <= adc_data;
      adc_s2 <= adc_s1;
    end
  end

  // ==========================================================================
  // Output cycle and host channel access
  logic [aio_pkg::DATA_W-1:0] ao_val [aio_pkg::NUM_AO];
  logic [aio_pkg::CH_W-1:0] out_slot;
  logic [aio_pkg::CH_W:0] hw;

  assign hw = word_of(host_addr);

  generate
    for (genvar g = 0; g < aio_pkg::NUM_AI; g++)
    begin : g_ch
      always_ff @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          ai_val[g] <= aio_pkg::DATA_RST;
          ao_val[g] <= aio_pkg::DATA_RST;
        end
        else
        begin
          if (mstate == AIO_M_CONV && slot_tick && adc_ch == aio_pkg::CH_W'(g))
          begin
            ai_val[g] <= adc_s2;
          end
          if (host_sel && host_we && hw[aio_pkg::CH_W] && hw[aio_pkg::CH_W-1:0] == g)
          begin
            ao_val[g] <= host_wdata;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_slot <= '0;
      dac_wr <= 1'b0;
      dac_ch <= '0;
      dac_data <= aio_pkg::DATA_RST;
      host_rdata <= aio_pkg::DATA_RST;
      host_ack <= 1'b0;
      addr_err <= 1'b0;
    end
    else
    begin
      // Slot advances whether or not its channel is enabled
      out_slot <= out_tick ? out_slot + 1'b1 : out_slot;
      dac_wr <= out_tick && act_ao[out_slot];
      dac_ch <= out_tick ? out_slot : dac_ch;
      dac_data <= out_tick ? ao_val[out_slot] : dac_data;
      host_ack <= host_sel && hw[aio_pkg::CH_W];
      addr_err <= host_sel && !hw[aio_pkg::CH_W];
      host_rdata <= (host_sel && !host_we && hw[aio_pkg::CH_W]) ?
                    ai_val[hw[aio_pkg::CH_W-1:0]] : host_rdata;
    end
  end

  // ==========================================================================
  // Checks
  logic [aio_pkg::CH_W-1:0] last_ch;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      last_ch <= '0;
    end
    else if (adc_start)
    begin
      last_ch <= adc_ch;
    end
  end

  a_odd_refused: assert property (@(posedge sys_clk) disable iff (!rst_b)
    host_sel && host_addr[0] |=> addr_err && !host_ack)
    else $error("odd byte address was accepted");
  a_shared_base: assert property (@(posedge sys_clk) disable iff (!rst_b)
    host_sel && host_we && host_addr == BASE_ADDR |=> ao_val[0] == $past(host_wdata))
    else $error("output 0 not at shared start address");
  a_only_enabled: assert property (@(posedge sys_clk) disable iff (!rst_b)
    adc_start |-> act_ai[adc_ch])
    else $error("disabled input converted");
  a_ascending_scan: assert property (@(posedge sys_clk) disable iff (!rst_b)
    adc_start && mstate == AIO_M_CONV && $past(mstate) == AIO_M_CONV |-> adc_ch > last_ch)
    else $error("channels not visited in ascending order");
  a_out_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b)
    out_tick && out_slot == aio_pkg::CH_W'(aio_pkg::OUT_SLOTS - 1) |=> out_slot == '0)
    else $error("output cycle not four slots");
  a_load_pending: assert property (@(posedge sys_clk) disable iff (!rst_b)
    prm_load && !run_rise |=> diag_en == $past(diag_en))
    else $error("parameter block applied on load");
  a_run_adopt: assert property (@(posedge sys_clk) disable iff (!rst_b)
    run_rise |=> diag_en == $past(pend_diag) && act_ai == $past(pend_ai))
    else $error("parameters not adopted at stop to run");
  a_static_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    run_q && cpu_run |=> $stable(diag_en))
    else $error("static parameter changed while running");
  a_cyclic_irq: assert property (@(posedge sys_clk) disable iff (!rst_b)
    run_q && act_mode == aio_pkg::MODE_CYCLIC && per_hit |=> hw_irq)
    else $error("cyclic interrupt missing");
  a_cend_irq: assert property (@(posedge sys_clk) disable iff (!rst_b)
    run_q && act_mode == aio_pkg::MODE_CEND && cyc_end |=> hw_irq ##1 !hw_irq)
    else $error("cycle end interrupt wrong");
endmodule

//--- bench/aio_host_model.sv
// Purpose: Behavioural host CPU for the scan sequencer: run mode, parameter blocks, channel access
// Assumes: Everything is driven 1 ns after the rising edge of sys_clk
// Notes: Fields are inverted after each load, so a late sample of them shows up
module aio_host_model (
  // Clock
  input wire logic sys_clk,
  // Mode and parameters
  output logic cpu_run,
  output logic prm_load,
  output logic dyn_load,
  output logic [aio_pkg::NUM_AI-1:0] prm_diag_en,
  output logic [aio_pkg::NUM_AI-1:0] prm_ai_en,
  output logic [aio_pkg::NUM_AO-1:0] prm_ao_en,
  output logic [1:0] prm_irq_mode,
  output logic [aio_pkg::TIME_W-1:0] prm_irq_time,
  // Channel access
  output logic host_sel,
  output logic host_we,
  output logic [aio_pkg::ADDR_W-1:0] host_addr,
  output logic [aio_pkg::DATA_W-1:0] host_wdata,
  input wire logic [aio_pkg::DATA_W-1:0] host_rdata,
  input wire logic host_ack,
  input wire logic addr_err
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {cpu_run, prm_load, dyn_load, host_sel, host_we} = 5'h00;
    {prm_diag_en, prm_ai_en, prm_ao_en, prm_irq_mode, prm_irq_time} = 19'h00000;
    {host_addr, host_wdata} = 32'h00000000;
  end
  // ==========================================================================
  // Parameter delivery: always the whole set, one strobe
  task automatic send(input logic [3:0] diag, ai, ao, input logic [1:0] mode,
                      input logic [4:0] tm, input logic dyn);
    @(posedge sys_clk) #1;
    {prm_diag_en, prm_ai_en, prm_ao_en, prm_irq_mode, prm_irq_time} = {diag, ai, ao, mode, tm};
    prm_load = !dyn;
    dyn_load = dyn;
    @(posedge sys_clk) #1;
    prm_load = 1'b0;
    dyn_load = 1'b0;
    {prm_diag_en, prm_ai_en, prm_ao_en, prm_irq_mode, prm_irq_time} = ~{diag, ai, ao, mode, tm};
  endtask
  task automatic set_run(input logic run);
    @(posedge sys_clk) #1;
    cpu_run = run;
  endtask
  // ==========================================================================
  // Channel access: one-cycle strobe, answer sampled on the following edge
  task automatic access(input logic we, input logic [15:0] addr, wdata,
                        output logic [15:0] rd, output logic ack, err);
    @(posedge sys_clk) #1;
    host_sel = 1'b1;
    host_we = we;
    host_addr = addr;
    host_wdata = wdata;
    @(posedge sys_clk) #1;
    host_sel = 1'b0;
    rd = host_rdata;
    ack = host_ack;
    err = addr_err;
    host_addr = ~addr;
    host_wdata = ~wdata;
  endtask
endmodule

//--- bench/aio_scan_seq_tb.sv
// Purpose: Self-checking bench for the analog I/O scan sequencer
// Assumes: Short counts in simulation: 8 cycles a slot, 4 cycles a time unit
// Notes: Converter returns A5C0 plus its channel number, so stored words are known
module aio_scan_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 8;
  localparam int UNIT = 4;
  localparam logic [15:0] BASE = 16'h0100;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] adc_data = 16'h0000;
  logic cpu_run, prm_load, dyn_load, host_sel, host_we, host_ack, addr_err;
  logic adc_start, dac_wr, meas_busy, hw_irq;
  logic [3:0] prm_diag_en, prm_ai_en, prm_ao_en, diag_en;
  logic [1:0] prm_irq_mode, adc_ch, dac_ch;
  logic [4:0] prm_irq_time;
  logic [15:0] host_addr, host_wdata, host_rdata, dac_data;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  always @(posedge sys_clk) adc_data <= #1 {12'hA5C, 2'h0, adc_ch};
  aio_scan_seq #(.CONV_CYCLES(CONV), .UNIT_CYCLES(UNIT)) u_aio_scan_seq (
    .sys_clk(sys_clk), .rst_b(rst_b), .cpu_run(cpu_run), .prm_load(prm_load),
    .dyn_load(dyn_load), .prm_diag_en(prm_diag_en), .prm_ai_en(prm_ai_en),
    .prm_ao_en(prm_ao_en), .prm_irq_mode(prm_irq_mode), .prm_irq_time(prm_irq_time),
    .host_sel(host_sel), .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_ack(host_ack), .addr_err(addr_err), .adc_data(adc_data),
    .adc_start(adc_start), .adc_ch(adc_ch), .dac_wr(dac_wr), .dac_ch(dac_ch),
    .dac_data(dac_data), .diag_en(diag_en), .meas_busy(meas_busy), .hw_irq(hw_irq));
  aio_host_model u_aio_host_model (
    .sys_clk(sys_clk), .cpu_run(cpu_run), .prm_load(prm_load), .dyn_load(dyn_load),
    .prm_diag_en(prm_diag_en), .prm_ai_en(prm_ai_en), .prm_ao_en(prm_ao_en),
    .prm_irq_mode(prm_irq_mode), .prm_irq_time(prm_irq_time), .host_sel(host_sel),
    .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_ack(host_ack), .addr_err(addr_err));
  // ==========================================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic ev(input logic irq, input logic [1:0] ch);
    ev = irq ? hw_irq === 1'b1 : (adc_start === 1'b1 && adc_ch === ch);
  endfunction
  // Bounded wait; a limit that runs out is a mismatch
  task automatic wait_ev(input logic irq, input logic [1:0] ch, input int lim, output int t);
    int n;
    n = 0;
    tick(1);
    while (!ev(irq, ch) && n < lim)
    begin
      tick(1);
      n++;
    end
    t = cyc;
    chk(16'(n < lim), 16'h0001);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_adopt();
    chk(16'(diag_en), 16'h0000);
    u_aio_host_model.send(4'h5, 4'hF, 4'hF, aio_pkg::MODE_NONE, 5'h00, 1'b0);
    tick(5);
    chk(16'(diag_en), 16'h0000);
    u_aio_host_model.set_run(1'b1);
    tick(2);
    chk(16'(diag_en), 16'h0005);
    u_aio_host_model.send(4'hA, 4'hF, 4'hF, aio_pkg::MODE_NONE, 5'h00, 1'b0);
    tick(40);
    chk(16'(diag_en), 16'h0005);
    u_aio_host_model.set_run(1'b0);
    tick(3);
    u_aio_host_model.set_run(1'b1);
    tick(2);
    chk(16'(diag_en), 16'h000A);
  endtask
  task automatic t_access();
    logic [15:0] rd;
    logic ack, err;
    logic [15:0] bad [4];
    bad = '{16'h0101, 16'h00FE, 16'h0108, 16'h0103};
    tick(80);
    for (int n = 0; n < 4; n++)
    begin
      u_aio_host_model.access(1'b0, 16'(BASE + 2 * n), 16'h0000, rd, ack, err);
      chk(rd, 16'hA5C0 | 16'(n));
      chk(16'(ack), 16'h0001);
      u_aio_host_model.access(1'b1, 16'(BASE + 2 * n), 16'h1230 + 16'(n), rd, ack, err);
      chk(16'(ack), 16'h0001);
    end
    foreach (bad[i])
    begin
      u_aio_host_model.access(1'b0, bad[i], 16'h0000, rd, ack, err);
      chk({ack, err}, 16'h0001);
    end
  endtask
  task automatic t_outputs();
    int cnt, last0;
    cnt = 0;
    last0 = -1;
    u_aio_host_model.send(4'hF, 4'hF, 4'hB, aio_pkg::MODE_NONE, 5'h00, 1'b1);
    tick(80);
    chk(16'(diag_en), 16'h000A);
    repeat (96)
    begin
      tick(1);
      if (dac_wr === 1'b1)
      begin
        cnt++;
        chk(dac_data, 16'h1230 + 16'(dac_ch));
        if (dac_ch === 2'h0 && last0 >= 0)
          chk(16'(cyc - last0), 16'(4 * CONV));
        if (dac_ch === 2'h0)
          last0 = cyc;
      end
    end
    chk(16'(cnt), 16'h0009);
  endtask
  task automatic t_inputs();
    int t0;
    logic [15:0] q[$];
    u_aio_host_model.send(4'h0, 4'hB, 4'hF, aio_pkg::MODE_NONE, 5'h00, 1'b1);
    tick(80);
    wait_ev(1'b0, 2'h0, 100, t0);
    chk(16'(meas_busy), 16'h0001);
    repeat (26)
    begin
      tick(1);
      if (adc_start === 1'b1)
        q.push_back({6'h00, adc_ch, 8'(cyc - t0)});
      if (cyc - t0 == 3 * CONV)
        chk(16'(meas_busy), 16'h0000);
    end
    chk(16'(q.size()), 16'h0003);
    chk(q[0], 16'h0108);
    chk(q[1], 16'h0310);
    chk(16'(q[2][15:8] == 8'h00 && q[2][7:0] >= 8'd24 && q[2][7:0] <= 8'd26), 16'h0001);
  endtask
  task automatic t_irq();
    int t0, t1, n, off;
    n = 0;
    off = 0;
    u_aio_host_model.send(4'h0, 4'hF, 4'hF, aio_pkg::MODE_CYCLIC, 5'h02, 1'b1);
    tick(80);
    wait_ev(1'b1, 2'h0, 40, t0);
    wait_ev(1'b1, 2'h0, 40, t1);
    chk(16'(t1 - t0), 16'(2 * UNIT));
    u_aio_host_model.send(4'h0, 4'hF, 4'hF, aio_pkg::MODE_CEND, 5'h0C, 1'b1);
    tick(120);
    wait_ev(1'b0, 2'h0, 100, t0);
    wait_ev(1'b0, 2'h0, 100, t1);
    chk(16'(t1 - t0), 16'(12 * UNIT));
    repeat (40)
    begin
      tick(1);
      if (hw_irq === 1'b1)
      begin
        n++;
        off = cyc - t1;
      end
    end
    chk(16'(n), 16'h0001);
    chk(16'(off >= 4 * CONV && off <= 4 * CONV + 2), 16'h0001);
  endtask
  // ==========================================================================
  // Verdict and run control
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #2000000;
    failures++;
    summarize();
  end
  initial
  begin
    tick(8);
    rst_b = 1'b1;
    t_adopt();
    t_access();
    t_outputs();
    t_inputs();
    t_irq();
    summarize();
  end
endmodule
